// ### ssr_map.vh
// Purpose: constants of the supply status register unit
// Assumes: nine-bit shared status layout
// Notes: included by ssr_status_unit.v
//
// Notes on behaviour
// - Status, accumulated, fault and mask registers share one nine-bit layout.
// - Present-status bits follow their live conditions continuously.
// - Status query returns sum of weights of true present-status bits.
// - Disable command inhibits output, leaving other settings untouched.
// - Programming commands still accepted and applied while output inhibited.
// - Enable command re-enables an output inhibited by command.
// - Accumulated register records every condition true since last read.
// - Fault and mask select which conditions may raise controller interrupts.
// - Fault register readable on its own as latched condition record.
// - Reading accumulated register loads it with present status.
// - Set mask bit lets status bit set fault bit; clear blocks.
// - Enabled fault bit sets on status rising edge, holds until read.
// - Reading fault register clears its bits, except one with an enabled rising edge in that cycle.
`ifndef SSR_MAP_VH
`define SSR_MAP_VH

// ----------------------------------------------------------------
// Status layout
// ----------------------------------------------------------------
`define SSR_WIDTH            9
`define SSR_BIT_CONST_VOLT   0
`define SSR_BIT_CONST_CURR   1
`define SSR_BIT_OR           2
`define SSR_BIT_OVP          3
`define SSR_BIT_THERM        4
`define SSR_BIT_LINE         5
`define SSR_BIT_LIMIT        6
`define SSR_BIT_PERR         7
`define SSR_BIT_INHIBIT      8

// ----------------------------------------------------------------
// Power-on values
// ----------------------------------------------------------------
`define SSR_MASK_RST         9'h000
`define SSR_FAULT_RST        9'h000
`define SSR_ACCUM_RST        9'h000
`define SSR_OUT_EN_RST       1'b1

`endif

// ### ssr_status_unit.v
// Purpose: status, accumulated, fault and mask registers plus output inhibit
// Assumes: condition inputs are asynchronous; commands are one-cycle pulses on clk
// Notes: query answers appear one cycle after the query strobe
`timescale 1ns/1ps
`include "ssr_map.vh"

module ssr_status_unit #(
   parameter WIDTH = `SSR_WIDTH
) (
   input  wire             clk,
   input  wire             srst,
   input  wire             const_voltage_flag,
   input  wire             const_current_flag,
   input  wire             overrange_flag,
   input  wire             voltage_protect_trip_flag,
   input  wire             thermal_trip_flag,
   input  wire             line_dropout_flag,
   input  wire             limit_shutdown_flag,
   input  wire             program_error_flag,
   input  wire             remote_inhibit_flag,
   input  wire             device_clear,
   input  wire             output_disable_cmd,
   input  wire             output_enable_cmd,
   input  wire             enable_select_cmd,
   input  wire [WIDTH-1:0] enable_select_data,
   input  wire             present_status_query,
   input  wire             accumulated_status_query,
   input  wire             fault_query,
   input  wire             mask_query,
   output reg  [WIDTH-1:0] read_data,
   output reg              read_valid,
   output reg              output_enable,
   output wire             fault_summary,
   output reg  [WIDTH-1:0] present_status
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire [WIDTH-1:0] raw_cond;                 // Conditions in layout order
   reg  [WIDTH-1:0] cond_meta;                // First capture stage
   reg  [WIDTH-1:0] prev_status;              // Present status one cycle back
   reg  [WIDTH-1:0] mask;                     // Conditions allowed into fault
   reg  [WIDTH-1:0] fault;                    // Latched enabled rising edges
   reg  [WIDTH-1:0] accumulated_status;       // Conditions seen since last read
   reg              fault_any;                // Registered fault summary
   wire [WIDTH-1:0] rise;                     // One-cycle rising edges
   wire [WIDTH-1:0] next_fault;
   wire [WIDTH-1:0] next_accumulated_status;
   reg  [WIDTH-1:0] next_read_data;
   reg              next_read_valid;
   reg              next_output_enable;
   wire             any_query;
   wire             clear_all;

   genvar           gi;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Fault bit update; a fresh enabled edge survives the read clear
   function fault_bit;
      input cur;
      input edge_seen;
      input allowed;
      input read_clear;
      begin
         if (read_clear) begin
            fault_bit = edge_seen & allowed;
         end else begin
            fault_bit = cur | (edge_seen & allowed);
         end
      end
   endfunction

   // Accumulated bit update; a read reloads from the live bit
   function accum_bit;
      input cur;
      input live;
      input read_reload;
      begin
         if (read_reload) begin
            accum_bit = live;
         end else begin
            accum_bit = cur | live;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Condition synchronisers
   // ----------------------------------------------------------------
   // Fixed bit order of the shared layout
   assign raw_cond[`SSR_BIT_CONST_VOLT] = const_voltage_flag;
   assign raw_cond[`SSR_BIT_CONST_CURR] = const_current_flag;
   assign raw_cond[`SSR_BIT_OR]         = overrange_flag;
   assign raw_cond[`SSR_BIT_OVP]        = voltage_protect_trip_flag;
   assign raw_cond[`SSR_BIT_THERM]      = thermal_trip_flag;
   assign raw_cond[`SSR_BIT_LINE]       = line_dropout_flag;
   assign raw_cond[`SSR_BIT_LIMIT]      = limit_shutdown_flag;
   assign raw_cond[`SSR_BIT_PERR]       = program_error_flag;
   assign raw_cond[`SSR_BIT_INHIBIT]    = remote_inhibit_flag;

   // Two-stage capture; second stage is the live present status
   always @(posedge clk) begin
      if (srst) begin
         cond_meta      <= {WIDTH{1'b0}};
         present_status <= {WIDTH{1'b0}};
         prev_status    <= {WIDTH{1'b0}};
      end else begin
         cond_meta      <= raw_cond;
         present_status <= cond_meta;
         prev_status    <= present_status;
      end
   end

   // ----------------------------------------------------------------
   // Per-bit edge detect and next values
   // ----------------------------------------------------------------
   // Same update for every status bit
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
         assign rise[gi] = present_status[gi] & ~prev_status[gi];
         assign next_fault[gi] = fault_bit(fault[gi], rise[gi], mask[gi],
                                           fault_query);
         assign next_accumulated_status[gi] = accum_bit(accumulated_status[gi],
                                                        present_status[gi],
                                                        accumulated_status_query);
      end
   endgenerate

   // Common clear for the command-held registers
   assign clear_all = srst | device_clear;

   // ----------------------------------------------------------------
   // Mask register
   // ----------------------------------------------------------------
   // Loaded by select command, also while the output is inhibited
   always @(posedge clk) begin
      if (clear_all) begin
         mask <= `SSR_MASK_RST;
      end else if (enable_select_cmd) begin
         mask <= enable_select_data;
      end
   end

   // ----------------------------------------------------------------
   // Fault register
   // ----------------------------------------------------------------
   // Latch and its summary share one clock edge
   always @(posedge clk) begin
      if (clear_all) begin
         fault     <= `SSR_FAULT_RST;
         fault_any <= |`SSR_FAULT_RST;
      end else begin
         fault     <= next_fault;
         fault_any <= |next_fault;
      end
   end

   // Summary of latched faults for service request logic
   assign fault_summary = fault_any;

   // ----------------------------------------------------------------
   // Accumulated register
   // ----------------------------------------------------------------
   // Read reloads from present status, otherwise ORs it in
   always @(posedge clk) begin
      if (clear_all) begin
         accumulated_status <= `SSR_ACCUM_RST;
      end else begin
         accumulated_status <= next_accumulated_status;
      end
   end

   // ----------------------------------------------------------------
   // Query answers
   // ----------------------------------------------------------------
   // Any query strobe produces one answer pulse
   assign any_query = present_status_query | accumulated_status_query |
                      fault_query | mask_query;

   // Answer select; binary value equals sum of weights of true bits
   always @* begin
      next_read_valid = any_query;
      next_read_data  = read_data;
      if (present_status_query) begin
         next_read_data = present_status;
      end else if (accumulated_status_query) begin
         next_read_data = accumulated_status;
      end else if (fault_query) begin
         next_read_data = fault;
      end else if (mask_query) begin
         next_read_data = mask;
      end
   end

   // Answer registers; data holds until the next query
   always @(posedge clk) begin
      if (srst) begin
         read_data  <= {WIDTH{1'b0}};
         read_valid <= 1'b0;
      end else begin
         read_data  <= next_read_data;
         read_valid <= next_read_valid;
      end
   end

   // ----------------------------------------------------------------
   // Output inhibit
   // ----------------------------------------------------------------
   // Only the enable bit changes; disable wins over enable
   always @* begin
      next_output_enable = output_enable;
      if (output_disable_cmd) begin
         next_output_enable = 1'b0;
      end else if (output_enable_cmd) begin
         next_output_enable = 1'b1;
      end
   end

   // Enable flop; programming paths stay open while inhibited
   always @(posedge clk) begin
      if (clear_all) begin
         output_enable <= `SSR_OUT_EN_RST;
      end else begin
         output_enable <= next_output_enable;
      end
   end

endmodule // ssr_status_unit

// ### ssr_status_unit_assertions.sv
// Purpose: port checker for the status unit
// Assumes: one clock, srst synchronous
// Notes: bound at the foot
`timescale 1ns/1ps
module ssr_chk #(
   parameter WIDTH = 9
) (
   input wire             clk,
   input wire             srst,
   input wire             device_clear,
   input wire             output_disable_cmd,
   input wire             output_enable_cmd,
   input wire             present_status_query,
   input wire             accumulated_status_query,
   input wire             fault_query,
   input wire             mask_query,
   input wire             read_valid,
   input wire             output_enable,
   input wire             fault_summary,
   input wire [WIDTH-1:0] read_data,
   input wire [WIDTH-1:0] present_status
);
   wire any_q = present_status_query | accumulated_status_query | fault_query | mask_query;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_disable_drops: assert property (output_disable_cmd && !device_clear |=> !output_enable)
      else $error("output not inhibited");
   a_enable_raises: assert property (output_enable_cmd && !output_disable_cmd |=> output_enable)
      else $error("output not enabled");
   a_query_answers: assert property (any_q |=> read_valid)
      else $error("query unanswered");
   a_valid_cause: assert property (read_valid |-> $past(any_q))
      else $error("answer without query");
   a_status_echo: assert property (present_status_query |=> read_data == $past(present_status))
      else $error("wrong status answer");
   a_clear_restores: assert property (device_clear && !output_disable_cmd && $stable(present_status)
      |=> output_enable && !fault_summary)
      else $error("clear incomplete");
   a_fault_clears: assert property (fault_query && $stable(present_status) ##1 $stable(present_status)
      |-> !fault_summary)
      else $error("fault not cleared");
   a_fault_holds: assert property (fault_summary && !fault_query && !device_clear |=> fault_summary)
      else $error("fault lost");
endmodule // ssr_chk
bind ssr_status_unit ssr_chk #(.WIDTH(WIDTH)) u_ssr_chk (.clk, .srst, .device_clear,
   .output_disable_cmd, .output_enable_cmd, .present_status_query, .accumulated_status_query,
   .fault_query, .mask_query, .read_valid, .output_enable, .fault_summary, .read_data,
   .present_status);

// ### ssr_ctrl_model.sv
// Purpose: controller sending one-cycle commands
// Assumes: bits disable,enable,select,status,accum,fault,mask,clear
// Notes: data is scrambled once released
`timescale 1ns/1ps
module ssr_ctrl_model (
   input  wire       clk,
   output reg  [7:0] cmd,
   output reg  [8:0] data
);
   initial begin
      cmd = 8'h00;
      data = 9'h000;
   end
   // One pulse at a falling edge
   task send(input [7:0] c, input [8:0] d);
      begin
         @(negedge clk);
         cmd = c;
         data = d;
         @(negedge clk);
         cmd = 8'h00;
         data = ~d;
      end
   endtask
endmodule // ssr_ctrl_model

// ### ssr_status_unit_tb_top.sv
// Purpose: bench for the status unit
// Assumes: conditions driven at falling edges
// Notes: status path is two edges deep
`timescale 1ns/1ps
module ssr_status_unit_tb_top;
   reg         clk, srst;
   reg  [8:0]  c;
   wire [7:0]  m;
   wire [8:0]  d, rdat, ps;
   wire        rv, oe, fs;
   integer     miscompares, comparisons;
   ssr_ctrl_model u_ssr_ctrl_model (.clk(clk), .cmd(m), .data(d));
   ssr_status_unit u_ssr_status_unit (.clk(clk), .srst(srst), .const_voltage_flag(c[0]),
      .const_current_flag(c[1]), .overrange_flag(c[2]), .voltage_protect_trip_flag(c[3]),
      .thermal_trip_flag(c[4]), .line_dropout_flag(c[5]), .limit_shutdown_flag(c[6]),
      .program_error_flag(c[7]), .remote_inhibit_flag(c[8]), .device_clear(m[7]),
      .output_disable_cmd(m[0]), .output_enable_cmd(m[1]), .enable_select_cmd(m[2]),
      .enable_select_data(d), .present_status_query(m[3]), .accumulated_status_query(m[4]),
      .fault_query(m[5]), .mask_query(m[6]), .read_data(rdat), .read_valid(rv),
      .output_enable(oe), .fault_summary(fs), .present_status(ps));
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   task chk(input [9:0] got, input [9:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task rd(input [7:0] q, input [8:0] exp);
      begin
         u_ssr_ctrl_model.send(q, 9'h000);
         chk({rv, rdat}, {1'b1, exp});
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task test_done;
      begin
         $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      miscompares = 0;
      comparisons = 0;
      srst = 1;
      c = 9'h000;
      cyc(20);
      srst = 0;
      chk({9'h000, oe}, 10'h001);
      c = 9'h081;
      cyc(3);
      chk({1'b0, ps}, 10'h081);
      rd(8'h08, 9'h081);
      c = 9'h000;
      cyc(3);
      rd(8'h10, 9'h081);
      u_ssr_ctrl_model.send(8'h04, 9'h004);
      c = 9'h006;
      cyc(1);
      c = 9'h000;
      cyc(4);
      rd(8'h10, 9'h006);
      rd(8'h20, 9'h004);
      rd(8'h20, 9'h000);
      c = 9'h010;
      cyc(3);
      c = 9'h000;
      rd(8'h10, 9'h010);
      rd(8'h10, 9'h010);
      u_ssr_ctrl_model.send(8'h01, 9'h000);
      chk({9'h000, oe}, 10'h000);
      u_ssr_ctrl_model.send(8'h04, 9'h1FF);
      rd(8'h40, 9'h1FF);
      u_ssr_ctrl_model.send(8'h02, 9'h000);
      chk({9'h000, oe}, 10'h001);
      u_ssr_ctrl_model.send(8'h01, 9'h000);
      c = 9'h004;
      cyc(1);
      c = 9'h000;
      cyc(4);
      chk({9'h000, fs}, 10'h001);
      u_ssr_ctrl_model.send(8'h80, 9'h000);
      chk({8'h00, fs, oe}, 10'h001);
      rd(8'h40, 9'h000);
      rd(8'h10, 9'h000);
      test_done;
   end
endmodule // ssr_status_unit_tb_top
